// >>> clock_gate_asserts.sv
// Port-level assertions for the run-mode peripheral clock gate
`timescale 1ns/10ps
`default_nettype none
module clock_gate_asserts
  import clock_gate_pkg::*;
(
  input wire logic                 clk_sys,
  input wire logic                 rst_n,
  input wire logic                 clkEn,
  input wire logic [ADDR_W-1:0]    regAddr,
  input wire logic [31:0]          regWrData,
  input wire logic                 regWr,
  input wire logic                 regRd,
  input wire logic [31:0]          regRdData,
  input wire logic [1:0]           powerMode,
  input wire logic                 unitAccess,
  input wire logic [3:0]           unitSel,
  input wire logic [NUM_UNITS-1:0] unitClkEn,
  input wire logic                 busFault,
  input wire logic                 irq
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  chk_reset_clears_outputs: assert property (disable iff (1'b0)
    !rst_n |=> unitClkEn == '0 && !busFault && !irq) else $error("reset left an output set");
  // Strobes seen while the clock enable is low are not taken
  chk_reserved_read_zero: assert property (
    clkEn && regRd && regAddr == RUN_GATE_OFFSET |=> (regRdData & ~GATE_WRITABLE_MASK) == '0)
    else $error("reserved gate bits read nonzero");
  chk_gate_read_back: assert property (
    clkEn && regWr && regAddr == RUN_GATE_OFFSET ##1 clkEn && !regWr ##1
    clkEn && regRd && regAddr == RUN_GATE_OFFSET
    |=> regRdData == ($past(regWrData, 3) & GATE_WRITABLE_MASK)) else $error("gate readback wrong");
  chk_offset_decode: assert property (
    clkEn && regRd && regAddr == 12'h100 |=> regRdData == '0) else $error("unmapped read nonzero");
  // Only the run table can be trusted here, so the mode must stay in run
  chk_gate_drives_clk: assert property (
    clkEn && regWr && regAddr == RUN_GATE_OFFSET ##1 clkEn && powerMode == 2'h0 |=> unitClkEn ==
    {$past(regWrData[26:24], 2), $past(regWrData[18:16], 2), $past(regWrData[12], 2),
     $past(regWrData[4], 2), $past(regWrData[1:0], 2)}) else $error("unit clocks wrong");
  chk_fault_unmapped: assert property (
    clkEn && unitAccess && unitSel > 4'h9 |=> busFault) else $error("no fault for bad unit");
  // A frozen cycle keeps an old fault pulse standing
  chk_fault_cause: assert property (
    busFault && $past(clkEn) |-> $past(unitAccess)) else $error("fault without access");
  chk_status_read_clears: assert property (
    clkEn && $past(clkEn) && regRd && regAddr == IRQ_STATUS_OFFSET && !unitAccess &&
    $stable(powerMode) |=> !irq)
    else $error("irq stayed after status read");
  cover property (busFault);
  cover property (irq);
  cover property (unitClkEn == '1);
endmodule // clock_gate_asserts
`default_nettype wire

// >>> clock_gate_pkg.sv
// Constants and types for the run-mode peripheral clock gate block
// Notes on behaviour
// [R1] Set bit clocks its unit, clear bit stops it
// [R2] Access to unclocked unit raises bus fault
// [R3] All gating bits reset to zero
// [R4] Run register applies only in running mode; the code also applies it in sleep and deep sleep while auto gating is clear
// [R5] Sleep registers used only with auto gating set
// [R6] Bits 26..24 gate comparators 2..0, read-write
// [R7] Bits 18..16 gate counters 2..0, read-write
// [R8] Bit 12 gates two-wire unit 0
// [R9] Bit 4 gates synchronous serial unit 0
// [R10] Bits 1..0 gate async ports 1..0
// [R11] Reserved bits read-only, read zero
// [R12] Software preserves reserved bits on updates
// [R13] Software enables units before using them
// [R14] Register decoded at offset 0x104
// [R15] Read returns last written gating bits
package clock_gate_pkg;
  localparam int          ADDR_W               = 12;
  localparam logic [11:0] RUN_GATE_OFFSET      = 12'h104;
  localparam logic [11:0] SLEEP_GATE_OFFSET    = 12'h114;
  localparam logic [11:0] DEEP_GATE_OFFSET     = 12'h124;
  localparam logic [11:0] RUN_CLOCK_CFG_OFFSET = 12'h060;
  localparam logic [11:0] IRQ_STATUS_OFFSET    = 12'h200;
  localparam logic [11:0] IRQ_MASK_OFFSET      = 12'h204;
  localparam logic [31:0] GATE_WRITABLE_MASK   = 32'h0707_1013;
  localparam logic [31:0] GATE_RESET           = 32'h0000_0000;
  localparam int          AUTO_GATING_BIT      = 27;
  localparam int          NUM_UNITS            = 10;
  localparam int          IRQ_FAULT_BIT        = 0;
  localparam int          IRQ_MODE_BIT         = 1;
  localparam logic [1:0]  IRQ_IMPL_MASK        = 2'h3;
  // Bit position of each gated unit, indexed by unit number
  localparam int UNIT_BIT [NUM_UNITS] = '{0, 1, 4, 12, 16, 17, 18, 24, 25, 26};

  typedef enum logic [1:0] {
    MODE_RUN   = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_DEEP  = 2'b10
  } power_mode_t;
endpackage : clock_gate_pkg

// >>> gate_reg_bank.sv
// Three gating registers (run, sleep, deep-sleep) with registered read port
`timescale 1ns/10ps
`default_nettype none
module gate_reg_bank
  import clock_gate_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  input  wire logic [1:0]  wrSel,
  input  wire logic        wrEn,
  input  wire logic [31:0] wrData,
  input  wire logic [1:0]  rdSel,
  output logic      [31:0] rdData,
  output logic      [31:0] runGate,
  output logic      [31:0] sleepGate,
  output logic      [31:0] deepGate
);
  typedef struct packed {
    logic [2:0][31:0] gate;
    logic [31:0]      rd;
  } bank_state_t;

  bank_state_t bank_reg;
  bank_state_t bank_next;

  always_comb begin
    bank_next = bank_reg;
    if (wrEn && wrSel != 2'b11) begin
      // Reserved positions never take a write
      bank_next.gate[wrSel] = wrData & GATE_WRITABLE_MASK; // see [R11]
    end
    bank_next.rd = (rdSel == 2'b11) ? 32'h0000_0000 : bank_reg.gate[rdSel]; // see [R15]
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bank_reg <= '{gate: {3{GATE_RESET}}, rd: 32'h0000_0000}; // see [R3]
    end else if (clkEn) begin
      bank_reg <= bank_next;
    end
  end

  assign rdData    = bank_reg.rd;
  assign runGate   = bank_reg.gate[0];
  assign sleepGate = bank_reg.gate[1];
  assign deepGate  = bank_reg.gate[2];
endmodule // gate_reg_bank
`default_nettype wire

// >>> run_mode_peripheral_clock_gate.sv
// Peripheral clock gating controller with register port, bus fault and interrupt
`timescale 1ns/10ps
`default_nettype none
module run_mode_peripheral_clock_gate
  import clock_gate_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 clkEn,
  input  wire logic [ADDR_W-1:0]    regAddr,
  input  wire logic [31:0]          regWrData,
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  output logic      [31:0]          regRdData,
  input  wire logic [1:0]           powerMode,
  input  wire logic                 unitAccess,
  input  wire logic [3:0]           unitSel,
  output logic      [NUM_UNITS-1:0] unitClkEn,
  output logic                      busFault,
  output logic                      irq
);
  typedef struct packed {
    logic [NUM_UNITS-1:0] clkEn;
    logic                 fault;
    logic                 autoGating;
    logic [1:0]           irqStatus;
    logic [1:0]           irqMask;
    logic                 irqOut;
    logic [31:0]          rdLocal;
    logic                 rdFromBank;
    power_mode_t          modeSeen;
  } top_state_t;

  top_state_t st_reg;
  top_state_t st_next;

  logic [31:0] runGate;
  logic [31:0] sleepGate;
  logic [31:0] deepGate;
  logic [31:0] bankRdData;
  logic [1:0]  bankWrSel;
  logic [1:0]  bankRdSel;
  logic        bankWrEn;
  logic [31:0] activeGate;
  power_mode_t modeNow;

  // Maps a register address onto a bank slot, 2'b11 when none
  function automatic logic [1:0] bank_slot(input logic [ADDR_W-1:0] a);
    unique case (a)
      RUN_GATE_OFFSET:   bank_slot = 2'b00; // see [R14]
      SLEEP_GATE_OFFSET: bank_slot = 2'b01;
      DEEP_GATE_OFFSET:  bank_slot = 2'b10;
      default:           bank_slot = 2'b11;
    endcase
  endfunction

  assign bankWrSel = bank_slot(regAddr);
  assign bankRdSel = bank_slot(regAddr);
  assign bankWrEn  = regWr;

  gate_reg_bank u_bank (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .wrSel    (bankWrSel),
    .wrEn     (bankWrEn),
    .wrData   (regWrData),
    .rdSel    (bankRdSel),
    .rdData   (bankRdData),
    .runGate  (runGate),
    .sleepGate(sleepGate),
    .deepGate (deepGate)
  );

  // Undefined mode codes fall back to running, the safe choice
  always_comb begin
    unique case (powerMode)
      2'b01:   modeNow = MODE_SLEEP;
      2'b10:   modeNow = MODE_DEEP;
      default: modeNow = MODE_RUN;
    endcase
  end

  // Sleep tables only matter once auto gating is enabled
  always_comb begin
    activeGate = runGate; // see [R4]
    if (st_reg.autoGating) begin
      unique case (modeNow)
        MODE_SLEEP: activeGate = sleepGate; // see [R5]
        MODE_DEEP:  activeGate = deepGate;  // see [R5]
        default:    activeGate = runGate;
      endcase
    end
  end

  always_comb begin
    logic [1:0] evt;
    evt = 2'b00;
    st_next = st_reg;
    st_next.modeSeen = modeNow;
    // Enables lag the register by one cycle; they feed clock-gate cells
    for (int i = 0; i < NUM_UNITS; i++) begin
      st_next.clkEn[i] = activeGate[UNIT_BIT[i]]; // see [R1] see [R6] see [R7] see [R8] see [R9] see [R10]
    end
    st_next.fault = 1'b0;
    if (unitAccess) begin
      if (unitSel >= 4'(NUM_UNITS) || !activeGate[UNIT_BIT[unitSel]]) begin
        st_next.fault = 1'b1; // see [R2]
        evt[IRQ_FAULT_BIT] = 1'b1;
      end
    end
    if (modeNow != st_reg.modeSeen) begin
      evt[IRQ_MODE_BIT] = 1'b1;
    end
    if (regWr) begin
      unique case (regAddr)
        RUN_CLOCK_CFG_OFFSET: st_next.autoGating = regWrData[AUTO_GATING_BIT];
        IRQ_MASK_OFFSET:      st_next.irqMask = regWrData[1:0] & IRQ_IMPL_MASK;
        default:              ;
      endcase
    end
    st_next.rdFromBank = 1'b0;
    st_next.rdLocal = 32'h0000_0000;
    if (regRd) begin
      unique case (regAddr)
        RUN_GATE_OFFSET, SLEEP_GATE_OFFSET, DEEP_GATE_OFFSET:
          st_next.rdFromBank = 1'b1; // see [R15]
        RUN_CLOCK_CFG_OFFSET:
          st_next.rdLocal[AUTO_GATING_BIT] = st_reg.autoGating;
        IRQ_STATUS_OFFSET: begin
          st_next.rdLocal[1:0] = st_reg.irqStatus;
          st_next.irqStatus = 2'b00;
        end
        IRQ_MASK_OFFSET:
          st_next.rdLocal[1:0] = st_reg.irqMask;
        default: ;
      endcase
    end
    // A new event beats a clearing read in the same cycle
    st_next.irqStatus = st_next.irqStatus | evt;
    st_next.irqOut = |(st_next.irqStatus & st_next.irqMask);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_reg <= '{clkEn: '0, fault: 1'b0, autoGating: 1'b0, irqStatus: 2'b00,
                  irqMask: 2'b00, irqOut: 1'b0, rdLocal: 32'h0000_0000,
                  rdFromBank: 1'b0, modeSeen: MODE_RUN}; // see [R3]
    end else if (clkEn) begin
      st_reg <= st_next;
    end
  end

  // Read data mux: both sources come straight from flip-flops
  assign regRdData = st_reg.rdFromBank ? bankRdData : st_reg.rdLocal;
  assign unitClkEn = st_reg.clkEn;
  assign busFault  = st_reg.fault;
  assign irq       = st_reg.irqOut;
endmodule // run_mode_peripheral_clock_gate
`default_nettype wire

// >>> run_mode_peripheral_clock_gate_tb.sv
// Self-checking bench for the run-mode peripheral clock gate
`timescale 1ns/10ps
`default_nettype none
module run_mode_peripheral_clock_gate_tb;
  import clock_gate_pkg::*;
  logic              clk_sys = 1'b0, rst_n = 1'b0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [31:0]       regWrData = '0, regRdData, gate, seed = 32'h0001_7e43;
  logic              regWr = 1'b0, regRd = 1'b0, unitAccess = 1'b0, busFault, irq, anyFault;
  logic              clkEn = 1'b1;
  logic [1:0]        powerMode = 2'h0;
  logic [3:0]        unitSel = 4'h0;
  logic [9:0]        unitClkEn;
  logic [10:0]       en;
  int                errCount = 0, comparisons = 0, cycles = 0;

  run_mode_peripheral_clock_gate i_run_mode_peripheral_clock_gate (.clk_sys(clk_sys),
    .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .powerMode(powerMode), .unitAccess(unitAccess),
    .unitSel(unitSel), .unitClkEn(unitClkEn), .busFault(busFault), .irq(irq));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [9:0] gmap(input logic [31:0] d);
    return {d[26:24], d[18:16], d[12], d[4], d[1:0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errCount++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic giveVerdict();
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One idle cycle between accesses; read data is sampled mid-cycle
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr <= w;
    regRd <= !w;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
    regRd <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic access(input logic [3:0] u);
    @(posedge clk_sys);
    unitAccess <= 1'b1;
    unitSel <= u;
    @(posedge clk_sys);
    unitAccess <= 1'b0;
    @(negedge clk_sys);
  endtask

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errCount++;
      giveVerdict();
    end
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    bus(1'b0, RUN_GATE_OFFSET, 32'h0);
    check(regRdData, GATE_RESET);
    bus(1'b0, 12'h100, 32'h0);
    check(regRdData, 32'h0);
    bus(1'b1, IRQ_MASK_OFFSET, 32'h1);
    $display("reset and decode test done");
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      gate = (i == 0) ? 32'hffff_ffff : seed;
      en = {1'b0, gmap(gate)};
      anyFault = 1'b0;
      bus(1'b1, RUN_GATE_OFFSET, gate);
      bus(1'b0, RUN_GATE_OFFSET, 32'h0);
      check(regRdData, gate & GATE_WRITABLE_MASK);
      check(32'(unitClkEn), 32'(en));
      for (int u = 0; u < 10 + i % 2; u++) begin
        access(4'(u));
        anyFault = anyFault | !en[u];
        check(32'(busFault), 32'(!en[u]));
      end
      check(32'(irq), 32'(anyFault));
      bus(1'b0, IRQ_STATUS_OFFSET, 32'h0);
      check(32'(regRdData[0]), 32'(anyFault));
      check(32'(irq), 32'h0);
    end
    $display("gating and fault test done");
    // A write strobed while frozen must not land
    @(posedge clk_sys);
    clkEn <= 1'b0;
    bus(1'b1, RUN_GATE_OFFSET, ~gate);
    @(posedge clk_sys);
    clkEn <= 1'b1;
    bus(1'b0, RUN_GATE_OFFSET, 32'h0);
    check(regRdData, gate & GATE_WRITABLE_MASK);
    check(32'(unitClkEn), 32'(en));
    bus(1'b1, RUN_GATE_OFFSET, regRdData | 32'h0000_0001);
    en = {1'b0, gmap(gate | 32'h0000_0001)};
    bus(1'b0, RUN_GATE_OFFSET, 32'h0);
    check(regRdData, (gate & GATE_WRITABLE_MASK) | 32'h0000_0001);
    check(32'(unitClkEn), 32'(en));
    $display("clock enable test done");
    @(posedge clk_sys);
    powerMode <= 2'h1;
    repeat (3) @(negedge clk_sys);
    check(32'(unitClkEn), 32'(en));
    bus(1'b0, IRQ_STATUS_OFFSET, 32'h0);
    check(regRdData, 32'h0000_0002);
    bus(1'b1, RUN_CLOCK_CFG_OFFSET, 32'h1 << AUTO_GATING_BIT);
    bus(1'b0, RUN_CLOCK_CFG_OFFSET, 32'h0);
    check(regRdData, 32'h1 << AUTO_GATING_BIT);
    bus(1'b1, SLEEP_GATE_OFFSET, 32'h0000_0001);
    bus(1'b0, SLEEP_GATE_OFFSET, 32'h0);
    check(regRdData, 32'h0000_0001);
    check(32'(unitClkEn), 32'h0000_0001);
    @(posedge clk_sys);
    powerMode <= 2'h2;
    bus(1'b1, DEEP_GATE_OFFSET, 32'h0400_0000);
    @(negedge clk_sys);
    check(32'(unitClkEn), 32'h0000_0200);
    bus(1'b1, IRQ_MASK_OFFSET, 32'h3);
    check(32'(irq), 32'h1);
    bus(1'b0, IRQ_STATUS_OFFSET, 32'h0);
    check(regRdData, 32'h0000_0002);
    check(32'(irq), 32'h0);
    // The unused mode code falls back to the run table
    @(posedge clk_sys);
    powerMode <= 2'h3;
    repeat (2) @(negedge clk_sys);
    check(32'(unitClkEn), 32'(en));
    check(32'(irq), 32'h1);
    $display("power mode test done");
    giveVerdict();
  end
endmodule // run_mode_peripheral_clock_gate_tb

bind run_mode_peripheral_clock_gate clock_gate_asserts i_clock_gate_asserts (
  .clk_sys   (clk_sys),
  .rst_n     (rst_n),
  .clkEn     (clkEn),
  .regAddr   (regAddr),
  .regWrData (regWrData),
  .regWr     (regWr),
  .regRd     (regRd),
  .regRdData (regRdData),
  .powerMode (powerMode),
  .unitAccess(unitAccess),
  .unitSel   (unitSel),
  .unitClkEn (unitClkEn),
  .busFault  (busFault),
  .irq       (irq)
);
`default_nettype wire
